// >>> common/wdt_pkg.sv
// constants, field layout and helpers for the watchdog time-out prescaler
// assumes one 200 MHz system clock; the slow oscillator is modelled by a divider
`default_nettype none

package wdt_pkg;
  // clock and oscillator timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int OSC_PERIOD_PS = 31250000;
  localparam int OSC_DIV_CYC = OSC_PERIOD_PS / CLK_PERIOD_PS;
  localparam int DIV_W = 16;

  // control register field positions
  localparam int FLAG_BIT = 7;
  localparam int IRQ_EN_BIT = 6;
  localparam int PERIOD_HI_BIT = 5;
  localparam int ENABLE_BIT = 3;
  localparam int PERIOD_LO_MSB = 2;

  // reset values
  localparam logic [3:0] PERIOD_RST = 4'h0;
  localparam logic ENABLE_RST = 1'b0;
  localparam logic IRQ_EN_RST = 1'b0;

  // period code range and counter sizing
  localparam logic [3:0] PERIOD_MAX_CODE = 4'h9;
  localparam int BASE_TIMEOUT = 512;
  localparam int CNT_W = 18;

  // change protection
  localparam logic [7:0] UNLOCK_SIGNATURE = 8'hd8;
  localparam logic [2:0] UNLOCK_WINDOW = 3'h4;

  // vector addresses
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [15:0] TIMEOUT_VECTOR = 16'h0004;

  // reserved codes fall back to the longest valid period
  function automatic logic [3:0] legal_code(input logic [3:0] c);
    return (c > PERIOD_MAX_CODE) ? PERIOD_MAX_CODE : c;
  endfunction

  // terminal count: 512 << code, minus one
  function automatic logic [CNT_W-1:0] timeout_limit(input logic [3:0] c);
    logic [CNT_W:0] t;
    t = (CNT_W+1)'(BASE_TIMEOUT) << legal_code(c);
    t = t - (CNT_W+1)'(1);
    return t[CNT_W-1:0];
  endfunction
endpackage

`default_nettype wire

// >>> common/wdt_count_if.sv
// carrier between the watchdog control logic and its period counter
// assumes both ends sit on the same system clock
`timescale 1ns/1ps
`default_nettype none

interface wdt_count_if;
  logic tick;
  logic clear;
  logic run;
  logic [3:0] code;
  logic timeout;

  modport ctrl (output tick, output clear, output run, output code, input timeout);
  modport counter (input tick, input clear, input run, input code, output timeout);
endinterface

`default_nettype wire

// >>> src/wdt_period_counter.sv
// oscillator-cycle counter that flags a time-out at the selected period
// assumes tick is a one-cycle pulse per oscillator cycle and code is legal
`timescale 1ns/1ps
`default_nettype none

module wdt_period_counter
  import wdt_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // link to control logic
  wdt_count_if.counter cif
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic timeout;
  } cnt_state_s;

  cnt_state_s st_ff;
  cnt_state_s nxt_st;

  // count ticks, wrap at the terminal count
  always_comb begin
    nxt_st = st_ff;
    nxt_st.timeout = 1'b0;
    if (!cif.run || cif.clear) begin
      nxt_st.cnt = '0; // R11
    end else if (cif.tick) begin
      if (st_ff.cnt == timeout_limit(cif.code)) begin
        nxt_st.cnt = '0;
        nxt_st.timeout = 1'b1; // R12
      end else begin
        nxt_st.cnt = st_ff.cnt + CNT_W'(1); // R2
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign cif.timeout = st_ff.timeout;

  // a time-out only ever follows the exact terminal count
  property p_timeout_at_limit; // R3
    @(posedge clk_sys) disable iff (srst)
      st_ff.timeout |-> $past(st_ff.cnt) == timeout_limit($past(cif.code)) && st_ff.cnt == '0;
  endproperty
  a_timeout_at_limit: assert property (p_timeout_at_limit) else $error("early or late timeout");

  // stopped or restarted counter holds zero
  property p_clear_holds; // R11
    @(posedge clk_sys) disable iff (srst)
      (!cif.run || cif.clear) |=> st_ff.cnt == '0 && !st_ff.timeout;
  endproperty
  a_clear_holds: assert property (p_clear_holds) else $error("counter not cleared");

endmodule

`default_nettype wire

// >>> src/watchdog_timeout_prescaler.sv
// watchdog time-out period selection, change protection and time-out action
// assumes cpu strobes are one-cycle pulses synchronous to clk_sys
//
// What this block does
// R1: period code at control bits 5 and 2:0
// R2: period code applies only while counter runs
// R3: codes 0..9 give 512 to 256K cycles
// R4: reserved codes fall back to a valid code
// R5: software writes unlock signature before code change
// R6: code write accepted within four instruction cycles
// R7: watchdog reset goes to vector 0x0000
// R8: enable bits pick stopped, reset or interrupt
// R9: interrupt time-out sets flag; ack or one clears
// R10: both bits set: time-out clears interrupt enable
// R11: counter cleared by restart, disable, chip reset
// R12: time-out when count reaches selected period
`timescale 1ns/1ps
`default_nettype none

module watchdog_timeout_prescaler
  import wdt_pkg::*;
#(
  parameter int OSC_DIV = OSC_DIV_CYC
)(
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // control register write
  input wire logic ctrl_wr,
  input wire logic [3:0] ctrl_wr_period,
  input wire logic ctrl_wr_enable,
  input wire logic ctrl_wr_irq_enable,
  input wire logic ctrl_wr_flag_clr,
  // change protection
  input wire logic change_protect_unlock,
  input wire logic [7:0] unlock_data,
  // cpu events
  input wire logic instr_cycle,
  input wire logic restart_instr,
  input wire logic irq_ack,
  // status and actions
  output logic [7:0] ctrl_rd,
  output logic [3:0] timeout_period_code,
  output logic watchdog_enable_bit,
  output logic timeout_irq_enable,
  output logic timeout_irq_flag,
  output logic unlock_open,
  output logic chip_reset_req,
  output logic [15:0] watchdog_timeout_vector
);

  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic tick;
    logic [3:0] period;
    logic en;
    logic ie;
    logic flag;
    logic [2:0] window;
    logic rst_req;
    logic run;
    logic clear;
    logic [15:0] vector;
  } wdt_state_s;

  wdt_state_s st_ff;
  wdt_state_s nxt_st;
  logic timeout;
  logic win_open;
  logic sig_ok;

  wdt_count_if cnt_if ();

  wdt_period_counter wdt_period_counter_inst (
    .clk_sys(clk_sys),
    .srst(srst),
    .cif(cnt_if)
  );

  assign timeout = cnt_if.timeout;
  assign win_open = (st_ff.window != 3'h0);
  assign sig_ok = change_protect_unlock && (unlock_data == UNLOCK_SIGNATURE);

  // next-state logic for divider, registers and time-out action
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rst_req = 1'b0;
    nxt_st.tick = 1'b0;

    // oscillator stand-in: one tick every OSC_DIV system cycles
    if (st_ff.div == DIV_W'(OSC_DIV - 1)) begin
      nxt_st.div = '0;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.div = st_ff.div + DIV_W'(1);
    end

    // unlock window counts down in instruction cycles
    if (sig_ok) begin
      nxt_st.window = UNLOCK_WINDOW; // R6
    end else if (instr_cycle && win_open) begin
      nxt_st.window = st_ff.window - 3'h1; // R6
    end

    // control write: period and disable need the open window
    if (ctrl_wr) begin
      if (win_open) begin
        nxt_st.period = ctrl_wr_period; // R6
        nxt_st.en = ctrl_wr_enable;
        nxt_st.window = 3'h0; // one protected write per unlock
      end else if (ctrl_wr_enable) begin
        nxt_st.en = 1'b1; // enabling needs no unlock
      end
      nxt_st.ie = ctrl_wr_irq_enable;
      if (ctrl_wr_flag_clr) begin
        nxt_st.flag = 1'b0; // R9
      end
    end
    if (irq_ack) begin
      nxt_st.flag = 1'b0; // R9
    end

    // time-out action; applied last so a set beats a same-cycle clear
    if (timeout) begin
      if (st_ff.ie) begin
        nxt_st.flag = 1'b1; // R9
        nxt_st.vector = TIMEOUT_VECTOR;
        if (st_ff.en) begin
          nxt_st.ie = 1'b0; // R10
        end
      end else if (st_ff.en) begin
        nxt_st.rst_req = 1'b1; // R8
        nxt_st.vector = RESET_VECTOR; // R7
      end
    end

    // counter runs in any mode but stopped; restart clears it
    nxt_st.run = nxt_st.en || nxt_st.ie; // R8
    nxt_st.clear = restart_instr; // R11
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_ff <= '0;
      st_ff.period <= PERIOD_RST;
      st_ff.en <= ENABLE_RST;
      st_ff.ie <= IRQ_EN_RST;
      st_ff.vector <= RESET_VECTOR;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // counter link; code limited to the legal range
  assign cnt_if.tick = st_ff.tick;
  assign cnt_if.run = st_ff.run; // R2
  assign cnt_if.clear = st_ff.clear;
  assign cnt_if.code = legal_code(st_ff.period); // R4

  // control register image, reserved bit reads zero
  always_comb begin
    ctrl_rd = 8'h00;
    ctrl_rd[FLAG_BIT] = st_ff.flag;
    ctrl_rd[IRQ_EN_BIT] = st_ff.ie;
    ctrl_rd[PERIOD_HI_BIT] = st_ff.period[3]; // R1
    ctrl_rd[ENABLE_BIT] = st_ff.en;
    ctrl_rd[PERIOD_LO_MSB:0] = st_ff.period[2:0]; // R1
  end

  // outputs straight from state flops
  assign timeout_period_code = st_ff.period;
  assign watchdog_enable_bit = st_ff.en;
  assign timeout_irq_enable = st_ff.ie;
  assign timeout_irq_flag = st_ff.flag;
  assign unlock_open = win_open;
  assign chip_reset_req = st_ff.rst_req;
  assign watchdog_timeout_vector = st_ff.vector;

  // code bits land at their documented positions
  property p_code_layout; // R1
    @(posedge clk_sys) disable iff (srst)
      ctrl_rd[5] == timeout_period_code[3] && ctrl_rd[2:0] == timeout_period_code[2:0]
        && ctrl_rd[4] == 1'b0;
  endproperty
  a_code_layout: assert property (p_code_layout) else $error("period code misplaced");

  // counter sees only legal codes
  property p_legal_code; // R4
    @(posedge clk_sys) disable iff (srst)
      cnt_if.code <= PERIOD_MAX_CODE
        && (timeout_period_code > PERIOD_MAX_CODE || cnt_if.code == timeout_period_code);
  endproperty
  a_legal_code: assert property (p_legal_code) else $error("reserved code reached counter");

  // locked write leaves the period untouched
  property p_locked_write; // R6
    @(posedge clk_sys) disable iff (srst)
      ctrl_wr && !unlock_open |=> timeout_period_code == $past(timeout_period_code);
  endproperty
  a_locked_write: assert property (p_locked_write) else $error("locked period changed");

  // signature opens the window, write then lands
  sequence s_unlock;
    change_protect_unlock && unlock_data == UNLOCK_SIGNATURE && !ctrl_wr;
  endsequence
  sequence s_write_now;
    ctrl_wr && !change_protect_unlock;
  endsequence
  property p_unlock_write; // R6
    @(posedge clk_sys) disable iff (srst)
      s_unlock ##1 s_write_now |=> timeout_period_code == $past(ctrl_wr_period);
  endproperty
  a_unlock_write: assert property (p_unlock_write) else $error("unlocked write dropped");

  // reset-mode time-out requests a chip reset to vector zero
  property p_reset_mode; // R8
    @(posedge clk_sys) disable iff (srst)
      timeout && watchdog_enable_bit && !timeout_irq_enable |=> chip_reset_req
        && watchdog_timeout_vector == 16'h0000;
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("missing watchdog reset");

  // reset request always carries the reset vector
  property p_reset_vector; // R7
    @(posedge clk_sys) disable iff (srst)
      chip_reset_req |-> watchdog_timeout_vector == RESET_VECTOR && !$past(timeout_irq_enable);
  endproperty
  a_reset_vector: assert property (p_reset_vector) else $error("wrong reset vector");

  // interrupt-mode time-out sets the flag, no reset
  property p_flag_set; // R9
    @(posedge clk_sys) disable iff (srst)
      timeout && timeout_irq_enable |=> timeout_irq_flag && !chip_reset_req;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set");

  // combined mode drops interrupt enable so the next time-out resets
  property p_ie_drop; // R10
    @(posedge clk_sys) disable iff (srst)
      timeout && watchdog_enable_bit && timeout_irq_enable |=> !timeout_irq_enable;
  endproperty
  a_ie_drop: assert property (p_ie_drop) else $error("interrupt enable kept");

endmodule

`default_nettype wire

// >>> tb/test_watchdog_timeout_prescaler.sv
// self-checking bench for the watchdog time-out prescaler
// assumes the design package and count interface are compiled first
`timescale 1ns/1ps
`default_nettype none

module test_watchdog_timeout_prescaler;
  import wdt_pkg::*;
  localparam int OD = 4; // short tick keeps code 2 under 10k clocks
  typedef struct {int sel; logic [15:0] v;} reg_note_s;
  typedef struct {int kind; int ticks; logic ien;} evt_note_s;
  logic clk_sys = 1'b0, srst = 1'b1, ctrl_wr = 1'b0, ctrl_wr_enable = 1'b0;
  logic [3:0] ctrl_wr_period = 4'h0;
  logic ctrl_wr_irq_enable = 1'b0, ctrl_wr_flag_clr = 1'b0, change_protect_unlock = 1'b0;
  logic [7:0] unlock_data = 8'h00;
  logic instr_cycle = 1'b0, restart_instr = 1'b0, irq_ack = 1'b0;
  logic [7:0] ctrl_rd;
  logic [3:0] timeout_period_code;
  logic watchdog_enable_bit, timeout_irq_enable, timeout_irq_flag, unlock_open, chip_reset_req;
  logic [15:0] watchdog_timeout_vector;
  int err_total = 0, comparisons = 0, cyc_n = 0, t_start = 0, seed = 32'hae39, k;
  logic [7:0] d;
  reg_note_s q_reg[$];
  evt_note_s q_evt[$];

  watchdog_timeout_prescaler #(.OSC_DIV(OD)) watchdog_timeout_prescaler_inst (
    .clk_sys(clk_sys), .srst(srst), .ctrl_wr(ctrl_wr), .ctrl_wr_period(ctrl_wr_period),
    .ctrl_wr_enable(ctrl_wr_enable), .ctrl_wr_irq_enable(ctrl_wr_irq_enable),
    .ctrl_wr_flag_clr(ctrl_wr_flag_clr), .change_protect_unlock(change_protect_unlock),
    .unlock_data(unlock_data), .instr_cycle(instr_cycle), .restart_instr(restart_instr),
    .irq_ack(irq_ack), .ctrl_rd(ctrl_rd), .timeout_period_code(timeout_period_code),
    .watchdog_enable_bit(watchdog_enable_bit), .timeout_irq_enable(timeout_irq_enable),
    .timeout_irq_flag(timeout_irq_flag), .unlock_open(unlock_open),
    .chip_reset_req(chip_reset_req), .watchdog_timeout_vector(watchdog_timeout_vector));

  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) cyc_n <= cyc_n + 1;

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic [15:0] obs(input int sel);
    case (sel)
      0: return {12'h000, timeout_period_code};
      1: return {8'h00, ctrl_rd};
      2: return {15'h0000, watchdog_enable_bit};
      3: return {15'h0000, timeout_irq_enable};
      4: return {15'h0000, timeout_irq_flag};
      5: return {15'h0000, unlock_open};
      default: return watchdog_timeout_vector;
    endcase
  endfunction

  // level checks just after the falling edge: a note sees the values of its own cycle
  always @(negedge clk_sys) begin
    #1;
    while (q_reg.size() > 0) begin
      reg_note_s n;
      n = q_reg.pop_front();
      check($sformatf("output %0d", n.sel), obs(n.sel), n.v);
    end
  end

  // event checks: time from last clear, action kind, vector, irq enable after
  logic prev_flag = 1'b0;
  always @(negedge clk_sys) begin
    evt_note_s e;
    if (chip_reset_req === 1'b1 || (timeout_irq_flag === 1'b1 && prev_flag !== 1'b1)) begin
      if (q_evt.size() == 0) begin
        check("unexpected timeout", 16'h0001, 16'h0000);
      end else begin
        e = q_evt.pop_front();
        check("action kind", {15'h0000, !chip_reset_req}, e.kind[15:0]);
        check("timeout span", {15'h0000, (cyc_n - t_start >= (e.ticks - 1) * OD) &&
          (cyc_n - t_start <= (e.ticks + 1) * OD + 4)}, 16'h0001);
        t_start = cyc_n;
        @(negedge clk_sys);
        check("vector", watchdog_timeout_vector, e.kind ? TIMEOUT_VECTOR : 16'h0000);
        check("irq enable after", {15'h0000, timeout_irq_enable}, {15'h0000, e.ien});
      end
    end
    prev_flag = timeout_irq_flag;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic look(input int sel, input logic [15:0] v);
    q_reg.push_back('{sel, v});
    cyc(1);
  endtask
  task automatic unlock(input logic [7:0] dv);
    change_protect_unlock = 1'b1;
    unlock_data = dv;
    cyc(1);
    change_protect_unlock = 1'b0;
  endtask
  task automatic wr(input logic [3:0] p, input logic en, input logic ie, input logic fc);
    {ctrl_wr, ctrl_wr_period, ctrl_wr_enable, ctrl_wr_irq_enable, ctrl_wr_flag_clr} =
      {1'b1, p, en, ie, fc};
    cyc(1);
    ctrl_wr = 1'b0;
    t_start = cyc_n;
    cyc(1);
  endtask
  task automatic pulse_instr();
    instr_cycle = 1'b1;
    cyc(1);
    instr_cycle = 1'b0;
    cyc(1); // idle cycle so back-to-back pulses never re-drive in one step
  endtask
  task automatic wait_evt();
    for (int i = 0; i < 20000 && q_evt.size() > 0; i++) cyc(1);
    if (q_evt.size() > 0) begin
      err_total++;
      stop_test();
    end
    cyc(3);
  endtask
  task automatic chip_reset();
    srst = 1'b1;
    cyc(4);
    srst = 1'b0;
    cyc(1);
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    cyc(4);
    srst = 1'b0;
    cyc(1);
    look(1, 16'h0000);
    look(6, 16'h0000);
    $display("test reset values done");
    // enable is free, period needs unlock; restart mid-run pushes time-out out
    q_evt.push_back('{0, 512, 1'b0});
    wr(4'h3, 1'b1, 1'b0, 1'b0);
    look(0, 16'h0000);
    cyc(1000);
    restart_instr = 1'b1;
    cyc(1);
    restart_instr = 1'b0;
    t_start = cyc_n;
    wait_evt();
    chip_reset();
    look(2, 16'h0000);
    $display("test reset mode done");
    // every code through the protected sequence, random delay inside window
    for (int c = 0; c < 16; c++) begin
      unlock(8'hd8);
      k = $unsigned($random(seed)) % 4;
      repeat (k) pulse_instr();
      look(5, 16'h0001);
      wr(c[3:0], 1'b0, 1'b0, 1'b0);
      look(0, {12'h000, c[3:0]});
      look(1, {8'h00, 2'b00, c[3], 2'b00, c[2:0]});
      look(5, 16'h0000);
    end
    $display("test period codes done");
    unlock(8'hd8);
    repeat (4) pulse_instr();
    cyc(2);
    look(5, 16'h0000);
    wr(4'h5, 1'b0, 1'b0, 1'b0);
    look(0, 16'h000f);
    d = 8'($random(seed));
    if (d == 8'hd8) d = 8'h5a;
    unlock(d);
    look(5, 16'h0000);
    wr(4'h2, 1'b0, 1'b0, 1'b0);
    look(0, 16'h000f);
    // enabling is free, disabling needs the unlock window
    wr(4'h5, 1'b1, 1'b0, 1'b0);
    look(2, 16'h0001);
    wr(4'h5, 1'b0, 1'b0, 1'b0);
    look(2, 16'h0001);
    unlock(8'hd8);
    wr(4'hf, 1'b0, 1'b0, 1'b0);
    look(2, 16'h0000);
    look(0, 16'h000f);
    $display("test protection done");
    // interrupt mode at codes 1 and 2, cleared by ack then by write-one
    for (int c = 1; c < 3; c++) begin
      unlock(8'hd8);
      q_evt.push_back('{1, 512 << c, 1'b1});
      wr(c[3:0], 1'b0, 1'b1, 1'b0);
      look(0, {12'h000, c[3:0]});
      wait_evt();
      look(4, 16'h0001);
      if (c == 1) begin
        irq_ack = 1'b1;
        cyc(1);
        irq_ack = 1'b0;
      end else wr(c[3:0], 1'b0, 1'b1, 1'b1);
      cyc(1);
      look(4, 16'h0000);
      wr(c[3:0], 1'b0, 1'b0, 1'b0);
    end
    cyc(3000); // stopped: no time-out allowed
    $display("test interrupt mode done");
    // both bits: first time-out interrupts and drops irq enable, next resets
    unlock(8'hd8);
    q_evt.push_back('{1, 512, 1'b0});
    q_evt.push_back('{0, 512, 1'b0});
    wr(4'h0, 1'b1, 1'b1, 1'b0);
    wait_evt();
    chip_reset();
    look(6, 16'h0000);
    $display("test combined mode done");
    stop_test();
  end
endmodule

`default_nettype wire
